// >>> include/slc_blink_if.sv
// interface carrying the two flash phases from the two blink generators
`timescale 1ns/1ps
interface slc_blink_if;
    logic slow_phase;
    logic fast_phase;
    modport src (output slow_phase, output fast_phase);
    modport dst (input slow_phase, input fast_phase);
endinterface

// >>> include/slc_pkg.sv
// package for the status indicator controller: constants, register map, states
package slc_pkg;
    localparam int unsigned CLK_HZ = 20000000;
    localparam int unsigned BIAS_TIME_S = 5;
    localparam int unsigned BIAS_CYCLES = CLK_HZ * BIAS_TIME_S;
    localparam int unsigned SLOW_HZ = 1;
    localparam int unsigned FAST_HZ = 2;
    localparam int unsigned SLOW_HALF = CLK_HZ / (2 * SLOW_HZ);
    localparam int unsigned FAST_HALF = CLK_HZ / (2 * FAST_HZ);
    localparam int unsigned CNT_W = 27;
    localparam int unsigned VOLT_W = 12;
    localparam int unsigned SAT_W = 6;
    localparam int unsigned ACC_W = 16;
    localparam int unsigned ADDR_W = 4;
    // reset values: battery thresholds in millivolts, minimum satellite count, accuracy limits
    localparam logic [VOLT_W-1:0] LOW_MV_RST = 12'hD48;
    localparam logic [VOLT_W-1:0] WARN_MV_RST = 12'hE10;
    localparam logic [SAT_W-1:0] MIN_SATS_RST = 6'h06;
    localparam logic [ACC_W-1:0] MAX_HACC_RST = 16'h1388;
    localparam logic [ACC_W-1:0] MAX_VACC_RST = 16'h1D4C;
    // register word addresses
    localparam logic [ADDR_W-1:0] REG_LOW_MV = 4'h0;
    localparam logic [ADDR_W-1:0] REG_WARN_MV = 4'h1;
    localparam logic [ADDR_W-1:0] REG_MIN_SATS = 4'h2;
    localparam logic [ADDR_W-1:0] REG_MAX_HACC = 4'h3;
    localparam logic [ADDR_W-1:0] REG_MAX_VACC = 4'h4;
    localparam logic [ADDR_W-1:0] REG_STATUS = 4'h5;
    localparam logic [ADDR_W-1:0] REG_IRQ_STAT = 4'h6;
    localparam logic [ADDR_W-1:0] REG_IRQ_CLR = 4'h7;
    localparam logic [ADDR_W-1:0] REG_IRQ_EN = 4'h8;
    localparam int unsigned IRQ_W = 3;
    localparam int unsigned IRQ_INIT = 0;
    localparam int unsigned IRQ_LOST = 1;
    localparam int unsigned IRQ_FAULT = 2;
    typedef enum logic [1:0] {SLC_BIAS, SLC_WAIT_FIX, SLC_NAV, SLC_FAULT} slc_state_t;
endpackage

// >>> rtl/slc_blink.sv
// blink generator: half-period counter toggling a fifty percent phase
`timescale 1ns/1ps
module slc_blink
    import slc_pkg::*;
#(
    parameter int unsigned HALF = SLOW_HALF
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // phase out
    output logic phase
);
    logic [CNT_W-1:0] cnt;
    localparam logic [CNT_W-1:0] LAST = CNT_W'(HALF - 1);
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cnt <= '0;
            phase <= 1'b0;
        end
        else if (cnt == LAST)
        begin
            cnt <= '0;
            phase <= ~phase;
        end
        else
            cnt <= cnt + 1'b1;
    end
endmodule

// >>> rtl/slc_sync.sv
// three-flop pin synchroniser; output changes once stages two and three agree
`timescale 1ns/1ps
module slc_sync (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // pin side
    input wire logic pin,
    output logic level
);
    logic s1;
    logic s2;
    logic s3;
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s1 <= 1'b0;
            s2 <= 1'b0;
            s3 <= 1'b0;
        end
        else
        begin
            s1 <= pin;
            s2 <= s1;
            s3 <= s2;
        end
    end
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            level <= 1'b0;
        else if (s2 == s3)
            level <= s3;
    end
endmodule

// >>> rtl/slc_top.sv
// status indicator controller: five front-panel leds and start-up gating
// How it works
// [R1] power led steady on while switched on, never flashes
// [R2] status led steady when solution healthy and card present
// [R3] status led dark before initialization or after reception degrades
// [R4] self-test fault during initialization flashes status led at 1 Hz
// [R5] healthy solution without storage card flashes status led at 2 Hz
// [R6] battery led flashes 1 Hz between low and warning thresholds
// [R7] battery led steady below low threshold
// [R8] battery led dark above warning threshold
// [R9] charging led follows charger charging state
// [R10] full led follows charger full state
// [R11] five second bias phase runs first after power-on
// [R12] initialization needs 3D fix with at least minimum satellite count
// [R13] initialization also needs accuracy better than configured limits
// [R14] status priority: fault, dark, no-card flash, steady
// [R15] flashes are fifty percent duty, counted from clock rate
//
// The implementer's own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
module slc_top
    import slc_pkg::*;
#(
    parameter int unsigned CLOCK_HZ = CLK_HZ,
    parameter int unsigned BIAS_LEN = CLOCK_HZ * BIAS_TIME_S
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // register port
    input wire logic [slc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic irq,
    // status inputs from the unit
    input wire logic power_on,
    input wire logic selftest_fault,
    input wire logic card_present,
    input wire logic fix_3d,
    input wire logic fix_healthy,
    input wire logic [slc_pkg::SAT_W-1:0] sat_count,
    input wire logic [slc_pkg::ACC_W-1:0] h_acc,
    input wire logic [slc_pkg::ACC_W-1:0] v_acc,
    input wire logic [slc_pkg::VOLT_W-1:0] batt_mv,
    input wire logic charging,
    input wire logic charge_full,
    // leds
    output logic led_power,
    output logic led_status,
    output logic led_battery,
    output logic led_charging,
    output logic led_full,
    output logic nav_solution_init
);
    import slc_pkg::*;

    logic card_s;
    logic chg_s;
    logic full_s;
    logic pwr_s;
    logic [VOLT_W-1:0] low_mv;
    logic [VOLT_W-1:0] warn_mv;
    logic [SAT_W-1:0] min_sats;
    logic [ACC_W-1:0] max_hacc;
    logic [ACC_W-1:0] max_vacc;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_en;
    logic [IRQ_W-1:0] irq_evt;
    logic [CNT_W-1:0] bias_cnt;
    slc_state_t state;
    slc_state_t next_state;
    logic fix_ok;
    logic next_status;
    logic next_battery;
    localparam logic [CNT_W-1:0] BIAS_LAST = CNT_W'(BIAS_LEN - 1);
    // bias and flash counts scale with the clock rate; the counter width caps that rate
    localparam int unsigned SLOW_LEN = CLOCK_HZ / (2 * SLOW_HZ);
    localparam int unsigned FAST_LEN = CLOCK_HZ / (2 * FAST_HZ);

    slc_blink_if blink ();

    // pins from other parts of the unit cross into this clock
    slc_sync u_sync_card (.sys_clk(sys_clk), .reset_n(reset_n), .pin(card_present),
        .level(card_s));
    slc_sync u_sync_chg (.sys_clk(sys_clk), .reset_n(reset_n), .pin(charging),
        .level(chg_s));
    slc_sync u_sync_full (.sys_clk(sys_clk), .reset_n(reset_n), .pin(charge_full),
        .level(full_s));
    slc_sync u_sync_pwr (.sys_clk(sys_clk), .reset_n(reset_n), .pin(power_on),
        .level(pwr_s));

    slc_blink #(.HALF(SLOW_LEN)) u_slow (.sys_clk(sys_clk), .reset_n(reset_n),
        .phase(blink.slow_phase)); // R15
    slc_blink #(.HALF(FAST_LEN)) u_fast (.sys_clk(sys_clk), .reset_n(reset_n),
        .phase(blink.fast_phase)); // R15

    // register writes
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            low_mv <= LOW_MV_RST;
            warn_mv <= WARN_MV_RST;
            min_sats <= MIN_SATS_RST;
            max_hacc <= MAX_HACC_RST;
            max_vacc <= MAX_VACC_RST;
            irq_en <= '0;
        end
        else if (reg_wr)
        begin
            unique case (reg_addr)
                REG_LOW_MV: low_mv <= reg_wdata[VOLT_W-1:0];
                REG_WARN_MV: warn_mv <= reg_wdata[VOLT_W-1:0];
                REG_MIN_SATS: min_sats <= reg_wdata[SAT_W-1:0];
                REG_MAX_HACC: max_hacc <= reg_wdata[ACC_W-1:0];
                REG_MAX_VACC: max_vacc <= reg_wdata[ACC_W-1:0];
                REG_IRQ_EN: irq_en <= reg_wdata[IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // register reads, data one cycle after the strobe; unmapped reads zero
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            reg_rdata <= '0;
        else if (reg_rd)
        begin
            unique case (reg_addr)
                REG_LOW_MV: reg_rdata <= 32'(low_mv);
                REG_WARN_MV: reg_rdata <= 32'(warn_mv);
                REG_MIN_SATS: reg_rdata <= 32'(min_sats);
                REG_MAX_HACC: reg_rdata <= 32'(max_hacc);
                REG_MAX_VACC: reg_rdata <= 32'(max_vacc);
                REG_STATUS: reg_rdata <= 32'({state, nav_solution_init});
                REG_IRQ_STAT: reg_rdata <= 32'(irq_stat);
                REG_IRQ_EN: reg_rdata <= 32'(irq_en);
                default: reg_rdata <= '0;
            endcase
        end
        else
            reg_rdata <= '0;
    end

    // strict accuracy comparisons: a fix exactly at an accuracy limit is not better than it
    assign fix_ok = fix_3d && (sat_count >= min_sats) // R12
        && (h_acc < max_hacc) && (v_acc < max_vacc); // R13

    // bias phase counter runs only in the bias state
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            bias_cnt <= '0;
        else if (state == SLC_BIAS && bias_cnt != BIAS_LAST)
            bias_cnt <= bias_cnt + 1'b1; // R11
    end

    always_comb
    begin
        next_state = state;
        unique case (state)
            SLC_BIAS:
                if (selftest_fault)
                    next_state = SLC_FAULT;
                else if (bias_cnt == BIAS_LAST)
                    next_state = SLC_WAIT_FIX; // R11
            SLC_WAIT_FIX:
                if (selftest_fault)
                    next_state = SLC_FAULT;
                else if (fix_ok)
                    next_state = SLC_NAV; // R12 R13
            SLC_NAV: next_state = SLC_NAV;
            SLC_FAULT: next_state = SLC_FAULT;
        endcase
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= SLC_BIAS;
            nav_solution_init <= 1'b0;
        end
        else
        begin
            state <= next_state;
            nav_solution_init <= (next_state == SLC_NAV);
        end
    end

    // status led with fixed priority
    always_comb
    begin
        if (state == SLC_FAULT)
            next_status = blink.slow_phase; // R4 R14
        else if (state != SLC_NAV || !fix_healthy)
            next_status = 1'b0; // R3 R14
        else if (!card_s)
            next_status = blink.fast_phase; // R5 R14
        else
            next_status = 1'b1; // R2 R14
    end

    always_comb
    begin
        if (batt_mv < low_mv)
            next_battery = 1'b1; // R7
        else if (batt_mv > warn_mv)
            next_battery = 1'b0; // R8
        else
            next_battery = blink.slow_phase; // R6
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            led_power <= 1'b0;
            led_status <= 1'b0;
            led_battery <= 1'b0;
            led_charging <= 1'b0;
            led_full <= 1'b0;
        end
        else
        begin
            led_power <= pwr_s; // R1
            led_status <= next_status;
            led_battery <= next_battery;
            led_charging <= chg_s; // R9
            led_full <= full_s; // R10
        end
    end

    // events: initialized, reception lost after init with the card present, fault entered
    assign irq_evt[IRQ_INIT] = (state != SLC_NAV) && (next_state == SLC_NAV);
    assign irq_evt[IRQ_LOST] = (state == SLC_NAV) && !fix_healthy && led_status
        && card_s;
    assign irq_evt[IRQ_FAULT] = (state != SLC_FAULT) && (next_state == SLC_FAULT);

    // a new event wins over a clear in the same cycle
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            irq_stat <= '0;
        else if (reg_wr && reg_addr == REG_IRQ_CLR)
            irq_stat <= (irq_stat & ~reg_wdata[IRQ_W-1:0]) | irq_evt;
        else
            irq_stat <= irq_stat | irq_evt;
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            irq <= 1'b0;
        else
            irq <= |(irq_stat & irq_en);
    end

    a_fault_slow_flash: assert property (@(posedge sys_clk) disable iff (!reset_n) // R4
        state == SLC_FAULT |=> led_status == $past(blink.slow_phase))
        else $error("status led not following slow flash in fault");
    a_dark_uninit: assert property (@(posedge sys_clk) disable iff (!reset_n) // R3
        state == SLC_WAIT_FIX |=> !led_status)
        else $error("status led lit before initialization");
    a_dark_degraded: assert property (@(posedge sys_clk) disable iff (!reset_n) // R3 R14
        (state == SLC_NAV && !fix_healthy) |=> !led_status)
        else $error("status led lit while reception degraded");
    a_nocard_fast: assert property (@(posedge sys_clk) disable iff (!reset_n) // R5
        (state == SLC_NAV && fix_healthy && !card_s)
        |=> led_status == $past(blink.fast_phase))
        else $error("no-card flash wrong");
    a_steady_ok: assert property (@(posedge sys_clk) disable iff (!reset_n) // R2
        (state == SLC_NAV && fix_healthy && card_s) |=> led_status)
        else $error("status led not steady when healthy");
    a_batt_low_on: assert property (@(posedge sys_clk) disable iff (!reset_n) // R7
        batt_mv < low_mv |=> led_battery)
        else $error("battery led not lit below low threshold");
    a_batt_high_off: assert property (@(posedge sys_clk) disable iff (!reset_n) // R8
        (batt_mv > warn_mv && batt_mv >= low_mv) |=> !led_battery)
        else $error("battery led lit above warning threshold");
    a_batt_mid_flash: assert property (@(posedge sys_clk) disable iff (!reset_n) // R6
        (batt_mv >= low_mv && batt_mv <= warn_mv)
        |=> led_battery == $past(blink.slow_phase))
        else $error("battery flash wrong");
    sequence s_bias_done;
        state == SLC_BIAS && bias_cnt == BIAS_LAST && !selftest_fault;
    endsequence
    a_bias_exit: assert property (@(posedge sys_clk) disable iff (!reset_n) // R11
        s_bias_done |=> state == SLC_WAIT_FIX)
        else $error("bias phase did not end on time");
    a_bias_hold: assert property (@(posedge sys_clk) disable iff (!reset_n) // R11
        (state == SLC_BIAS && bias_cnt != BIAS_LAST) |=> state != SLC_WAIT_FIX)
        else $error("left bias phase early");
    a_init_gate: assert property (@(posedge sys_clk) disable iff (!reset_n) // R12 R13
        $rose(nav_solution_init) |-> $past(fix_ok))
        else $error("initialized without a good fix");
    a_power_follow: assert property (@(posedge sys_clk) disable iff (!reset_n) // R1
        led_power == $past(pwr_s))
        else $error("power led not following power state");
    a_charge_follow: assert property (@(posedge sys_clk) disable iff (!reset_n) // R9 R10
        led_charging == $past(chg_s) && led_full == $past(full_s))
        else $error("charge leds wrong");
endmodule

// >>> tb/slc_led_panel.sv
// model of the five front-panel leds: what a viewer sees and power led changes
`timescale 1ns/1ps
module slc_led_panel (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // leds from the controller
    input wire logic led_power,
    input wire logic led_status,
    input wire logic led_battery,
    input wire logic led_charging,
    input wire logic led_full,
    // observation
    output logic [4:0] lit,
    output logic [7:0] power_changes
);
    logic last_power;

    // leds are plain loads, so the lit pattern is simply the drive levels
    assign lit = {led_full, led_charging, led_battery, led_status, led_power};

    // counting changes shows a flashing power led, which a level check would miss
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            last_power <= 1'b0;
            power_changes <= '0;
        end
        else
        begin
            last_power <= led_power;
            if (led_power != last_power)
                power_changes <= power_changes + 8'h01;
        end
    end
endmodule

// >>> tb/tb.sv
// self-checking bench for the status indicator controller
`timescale 1ns/1ps
module tb;
    import slc_pkg::*;
    localparam int unsigned BIAS_SIM = 50;
    // a low clock rate gives flash half periods of 20 and 10 cycles
    localparam int unsigned SIM_HZ = 40;
    localparam int unsigned SLOW_P = SIM_HZ / SLOW_HZ;
    localparam int unsigned FAST_P = SIM_HZ / FAST_HZ;
    localparam int LIMIT = 3000;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [31:0] reg_wdata = '0;
    logic reg_wr = 1'b0, reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic irq, nav_solution_init;
    logic power_on = 1'b0, selftest_fault = 1'b0, card_present = 1'b0;
    logic fix_3d = 1'b0, fix_healthy = 1'b0, charging = 1'b0, charge_full = 1'b0;
    logic [SAT_W-1:0] sat_count = '0;
    logic [ACC_W-1:0] h_acc = '0, v_acc = '0;
    logic [VOLT_W-1:0] batt_mv = 12'hFA0;
    logic led_power, led_status, led_battery, led_charging, led_full;
    logic [4:0] lit;
    logic [7:0] power_changes;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;
    int lit_high = 0;

    always #25 sys_clk = ~sys_clk;

    slc_top #(.CLOCK_HZ(SIM_HZ), .BIAS_LEN(BIAS_SIM)) slc_top_i (
        .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .power_on(power_on), .selftest_fault(selftest_fault), .card_present(card_present),
        .fix_3d(fix_3d), .fix_healthy(fix_healthy), .sat_count(sat_count), .h_acc(h_acc),
        .v_acc(v_acc), .batt_mv(batt_mv), .charging(charging), .charge_full(charge_full),
        .led_power(led_power), .led_status(led_status), .led_battery(led_battery),
        .led_charging(led_charging), .led_full(led_full),
        .nav_solution_init(nav_solution_init)
    );

    slc_led_panel slc_led_panel_i (
        .sys_clk(sys_clk), .reset_n(reset_n), .led_power(led_power),
        .led_status(led_status), .led_battery(led_battery), .led_charging(led_charging),
        .led_full(led_full), .lit(lit), .power_changes(power_changes)
    );

    task automatic give_verdict;
        if (miscompares == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask

    // any window of one full flash period holds exactly half a period of lit samples
    task automatic count_lit(input int idx, input int n, output int hi);
        hi = 0;
        repeat (n)
        begin
            @(posedge sys_clk);
            #1;
            if (lit[idx] === 1'b1)
                hi++;
        end
    endtask

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == LIMIT)
        begin
            miscompares++;
            give_verdict;
        end
    end

    initial
    begin
        cyc(4);
        reset_n <= 1'b1;
        rd_chk(REG_LOW_MV, {20'h0, LOW_MV_RST});
        rd_chk(REG_WARN_MV, {20'h0, WARN_MV_RST});
        rd_chk(REG_MIN_SATS, {26'h0, MIN_SATS_RST});
        rd_chk(REG_MAX_HACC, {16'h0, MAX_HACC_RST});
        rd_chk(REG_MAX_VACC, {16'h0, MAX_VACC_RST});
        rd_chk(REG_STATUS, {29'h0, SLC_BIAS, 1'b0});
        rd_chk(4'h9, 32'h0);
        wr(REG_IRQ_EN, 32'h7);
        // pins pass a three-flop synchroniser, hence the longer settle
        power_on <= 1'b1;
        charging <= 1'b1;
        cyc(8);
        check(lit, 5'b01001);
        charging <= 1'b0;
        charge_full <= 1'b1;
        cyc(8);
        check(lit, 5'b10001);
        batt_mv <= 12'hBB8;
        cyc(3);
        check(led_battery, 1'b1);
        batt_mv <= 12'hDAC;
        cyc(3);
        count_lit(2, SLOW_P, lit_high);
        check(lit_high, SLOW_P / 2);
        wr(REG_LOW_MV, 32'hE10);
        cyc(3);
        check(led_battery, 1'b1);
        batt_mv <= 12'hE11;
        cyc(3);
        check(led_battery, 1'b0);
        cyc(40);
        rd_chk(REG_STATUS, {29'h0, SLC_WAIT_FIX, 1'b0});
        fix_3d <= 1'b1;
        sat_count <= 6'h05;
        h_acc <= 16'h1387;
        v_acc <= 16'h1D4B;
        cyc(4);
        check(nav_solution_init, 1'b0);
        sat_count <= 6'h06;
        h_acc <= 16'h1388;
        cyc(4);
        check(nav_solution_init, 1'b0);
        h_acc <= 16'h1387;
        v_acc <= 16'h1D4C;
        cyc(4);
        check(nav_solution_init, 1'b0);
        v_acc <= 16'h1D4B;
        cyc(4);
        check(nav_solution_init, 1'b1);
        check(irq, 1'b1);
        rd_chk(REG_STATUS, {29'h0, SLC_NAV, 1'b1});
        rd_chk(REG_IRQ_STAT, 32'h1);
        wr(REG_IRQ_CLR, 32'h1);
        cyc(2);
        check(irq, 1'b0);
        fix_healthy <= 1'b1;
        card_present <= 1'b1;
        cyc(8);
        check(led_status, 1'b1);
        card_present <= 1'b0;
        cyc(8);
        count_lit(1, FAST_P, lit_high);
        check(lit_high, FAST_P / 2);
        card_present <= 1'b1;
        cyc(8);
        check(led_status, 1'b1);
        fix_healthy <= 1'b0;
        cyc(3);
        check(led_status, 1'b0);
        rd_chk(REG_IRQ_STAT, 32'h2);
        check(irq, 1'b1);
        power_on <= 1'b0;
        cyc(8);
        check(led_power, 1'b0);
        check(power_changes, 8'h02);
        // a second power-up with a self-test fault during the bias phase
        reset_n <= 1'b0;
        fix_3d <= 1'b0;
        fix_healthy <= 1'b1;
        cyc(4);
        reset_n <= 1'b1;
        selftest_fault <= 1'b1;
        wr(REG_IRQ_EN, 32'h4);
        cyc(4);
        rd_chk(REG_STATUS, {29'h0, SLC_FAULT, 1'b0});
        count_lit(1, SLOW_P, lit_high);
        check(lit_high, SLOW_P / 2);
        rd_chk(REG_IRQ_STAT, 32'h4);
        check(irq, 1'b1);
        // bias phase boundary, read once in its last cycle and once just after it
        reset_n <= 1'b0;
        selftest_fault <= 1'b0;
        cyc(4);
        reset_n <= 1'b1;
        cyc(BIAS_SIM - 2);
        rd_chk(REG_STATUS, {29'h0, SLC_BIAS, 1'b0});
        reset_n <= 1'b0;
        cyc(4);
        reset_n <= 1'b1;
        cyc(BIAS_SIM - 1);
        rd_chk(REG_STATUS, {29'h0, SLC_WAIT_FIX, 1'b0});
        give_verdict;
    end
endmodule
